// ==== fsae_map.svh ====
// Register offsets, status bit positions, function codes and exception codes
// of the fault/status bank.
// Assumes it is included by its bare name from every design file that needs it.
`ifndef FSAE_MAP_SVH
`define FSAE_MAP_SVH

// Register numbers as seen on the serial link, bank size, reserved word value and status reset value.
`define FSAE_REG_STATUS 16'h02BC
`define FSAE_REG_RSVD 16'h02BD
`define FSAE_REG_COUNT 16'h0002
`define FSAE_RSVD_VALUE 16'h0000
`define FSAE_STATUS_RST 16'h0000

// Status bit positions.
`define FSAE_BIT_PARITY 0
`define FSAE_BIT_FRAMING 1
`define FSAE_BIT_TEMP_HI 2
`define FSAE_BIT_TEMP_LO 3
`define FSAE_BIT_MEAS_HI 4
`define FSAE_BIT_MEAS_LO 5
`define FSAE_BIT_CAL_FAIL 6
`define FSAE_BIT_NV_FAIL 7
`define FSAE_BIT_ACCEL_FAIL 8
`define FSAE_BIT_TEST_MODE 11
`define FSAE_BIT_WATCHDOG 12
`define FSAE_BIT_BROWNOUT 13

// Bits that survive a diagnostic clear: the two load failures and test mode.
`define FSAE_DIAG_KEEP_MASK 16'h08C0

// Function codes, diagnostic sub-functions, exception answers and the read quantity limit.
`define FSAE_FC_RD_HOLD 8'h03
`define FSAE_FC_RD_INPUT 8'h04
`define FSAE_FC_DIAG 8'h08
`define FSAE_SFC_RET_DIAG 16'h0002
`define FSAE_SFC_CLR_DIAG 16'h000A
`define FSAE_EXC_FLAG 8'h80
`define FSAE_EXC_NONE 8'h00
`define FSAE_EXC_FUNC 8'h01
`define FSAE_EXC_ADDR 8'h02
`define FSAE_EXC_VALUE 8'h03
`define FSAE_MAX_QTY 16'h007D

`endif

// ==== fsae_pkg.sv ====
// Types shared by the fault/status bank and its request handler.
// Assumes nothing of its surroundings.
package fsae_pkg;

  typedef logic [15:0] fsae_word_t;

  // Handler states.
  typedef enum logic [1:0] {FSAE_IDLE, FSAE_SEND, FSAE_EXC} fsae_state_t;

  // Outcome of checking one request.
  typedef enum logic [1:0] {FSAE_DROP, FSAE_DATA, FSAE_ECHO, FSAE_FAULT} fsae_dec_t;

endpackage

// ==== fsae_status_bank.sv ====
// Status word flip-flops: sticky fault bits, live range bits and boot causes.
// Assumes every event input is a one-cycle pulse or level from logic on ref_clk.
`timescale 1ns/1ps
`include "fsae_map.svh"

module fsae_status_bank
  import fsae_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic parityErr,
  input wire logic framingErr,
  input wire logic overrunErr,
  input wire logic tempHigh,
  input wire logic tempLow,
  input wire logic measHigh,
  input wire logic measLow,
  input wire logic calLoadFail,
  input wire logic nvLoadFail,
  input wire logic accelFail,
  input wire logic testModeEnter,
  input wire logic testModeExitCmd,
  input wire logic wdtCause,
  input wire logic porCause,
  input wire logic commResetCoil,
  input wire logic sensorResetCoil,
  input wire logic diagClear,
  output fsae_word_t statusWord
);

  logic bootSeen_r;
  fsae_word_t status_r;
  fsae_word_t status_nxt;

  // Boot causes are caught on the first edge after reset release, never under reset.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bootSeen_r <= 1'b0;
    end else begin
      bootSeen_r <= 1'b1;
    end
  end

  // Clears come first and sets after them, so an event in a clear cycle is kept.
  always_comb begin
    status_nxt = status_r;
    if (commResetCoil) begin
      status_nxt[`FSAE_BIT_PARITY] = 1'b0;
      status_nxt[`FSAE_BIT_FRAMING] = 1'b0;
    end
    if (sensorResetCoil) begin
      status_nxt[`FSAE_BIT_CAL_FAIL] = 1'b0;
      status_nxt[`FSAE_BIT_NV_FAIL] = 1'b0;
      status_nxt[`FSAE_BIT_ACCEL_FAIL] = 1'b0;
    end
    if (diagClear) begin
      status_nxt = status_nxt & `FSAE_DIAG_KEEP_MASK;
    end
    if (testModeExitCmd) begin
      status_nxt[`FSAE_BIT_TEST_MODE] = 1'b0;
    end
    status_nxt[`FSAE_BIT_PARITY] = status_nxt[`FSAE_BIT_PARITY] | parityErr;
    status_nxt[`FSAE_BIT_FRAMING] = status_nxt[`FSAE_BIT_FRAMING] | framingErr | overrunErr;
    // Range bits follow their condition, so they clear by themselves on return.
    status_nxt[`FSAE_BIT_TEMP_HI] = tempHigh;
    status_nxt[`FSAE_BIT_TEMP_LO] = tempLow;
    status_nxt[`FSAE_BIT_MEAS_HI] = measHigh;
    status_nxt[`FSAE_BIT_MEAS_LO] = measLow;
    status_nxt[`FSAE_BIT_CAL_FAIL] = status_nxt[`FSAE_BIT_CAL_FAIL] | calLoadFail;
    status_nxt[`FSAE_BIT_NV_FAIL] = status_nxt[`FSAE_BIT_NV_FAIL] | nvLoadFail;
    status_nxt[`FSAE_BIT_ACCEL_FAIL] = status_nxt[`FSAE_BIT_ACCEL_FAIL] | accelFail;
    status_nxt[`FSAE_BIT_TEST_MODE] = status_nxt[`FSAE_BIT_TEST_MODE] | testModeEnter;
    if (!bootSeen_r) begin
      status_nxt[`FSAE_BIT_WATCHDOG] = status_nxt[`FSAE_BIT_WATCHDOG] | wdtCause;
      status_nxt[`FSAE_BIT_BROWNOUT] = status_nxt[`FSAE_BIT_BROWNOUT] | porCause;
    end
  end

  // A reset is the power cycle: every bit starts clear.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      status_r <= `FSAE_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign statusWord = status_r;

  chk_parity_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    parityErr |=> statusWord[0]) else $error("parity error not flagged");
  chk_comm_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    commResetCoil && !framingErr && !overrunErr |=> !statusWord[1])
    else $error("framing bit survived comm reset");
  chk_temp_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 statusWord[2] == $past(tempHigh)) else $error("temp high bit lags");
  chk_temp_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 statusWord[3] == $past(tempLow)) else $error("temp low bit lags");
  chk_cal_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
    statusWord[6] && !sensorResetCoil |=> statusWord[6]) else $error("cal fail bit lost");
  chk_accel_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    accelFail |=> statusWord[8]) else $error("accel fail not flagged");
  chk_test_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    statusWord[11] && !testModeExitCmd |=> statusWord[11]) else $error("test bit dropped");
  chk_boot_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    !bootSeen_r && porCause |=> statusWord[13] && bootSeen_r) else $error("brownout missed");

endmodule

// ==== fsae_fault_status.sv ====
// Fault/status bank with its request checker: serves status reads, the
// diagnostic read and clear, and answers malformed accesses with exceptions.
// Assumes a frame parser on ref_clk that has checked CRC and routed the
// request here, and a transmitter that takes answer words with rspReady.
`timescale 1ns/1ps
`include "fsae_map.svh"

////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// - Status word at 700, MSB first, read by 03, 04 or diagnostic 08:02.
// - Parity error sets bit 0; comm reset coil clears it.
// - Framing or overrun error sets bit 1; comm reset coil clears it.
// - Bit 2 shows temperature above calibrated maximum.
// - Bit 3 shows temperature below calibrated minimum.
// - Measurement above maximum sets bit 4 and clamps output high.
// - Measurement below minimum sets bit 5 and clamps output low.
// - Calibration table load failure sets bit 6; only reset or coil clears.
// - Settings restore failure sets bit 7; only reset or coil clears.
// - Accelerometer identify, configure or self-test failure sets bit 8.
// - Test mode sets bit 11 until the test mode exit command.
// - Restart from watchdog timeout sets bit 12.
// - Power-on or brownout start sets bit 13 until cleared.
// - Register 701 is reserved, read-only, readable by 03 and 04 only.
// - Reads beyond the bank with a valid quantity get an address exception, not data.
// - Writes to the bank get an illegal function exception.
// - Exceptions are only sent for well-formed requests.
// - Function not allowed for the range answers code 01.
// - Start or start plus quantity out of range answers code 02 when the quantity itself is valid.
// - Invalid data value, such as zero quantity, answers code 03.
// - Diagnostic 08 sub-code 10 clears the diagnostic bits.
// - Status mirrored big-endian at 200 and byte-swapped at 100.
module fsae_fault_status
  import fsae_pkg::*;
#(
  parameter int MEAS_W = 16,
  parameter logic signed [MEAS_W-1:0] MEAS_MAX = 16'sh4000,
  parameter logic signed [MEAS_W-1:0] MEAS_MIN = 16'shC000,
  parameter int TEMP_W = 16,
  parameter logic signed [TEMP_W-1:0] TEMP_MAX = 16'sh0055,
  parameter logic signed [TEMP_W-1:0] TEMP_MIN = 16'shFFD8
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqFrameOk,
  input wire logic [7:0] reqFunc,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqQty,
  output logic rspValid,
  input wire logic rspReady,
  output logic rspExc,
  output logic [7:0] rspFunc,
  output logic [7:0] rspExcCode,
  output fsae_word_t rspWord,
  output logic rspLast,
  input wire logic parityErr,
  input wire logic framingErr,
  input wire logic overrunErr,
  input wire logic signed [TEMP_W-1:0] tempRaw,
  input wire logic signed [MEAS_W-1:0] measRaw,
  output logic signed [MEAS_W-1:0] measOut,
  input wire logic calLoadFail,
  input wire logic nvLoadFail,
  input wire logic accelFail,
  input wire logic testModeEnter,
  input wire logic testModeExitCmd,
  input wire logic wdtCause,
  input wire logic porCause,
  input wire logic commResetCoil,
  input wire logic sensorResetCoil,
  output fsae_word_t statusWord,
  output fsae_word_t mirrorBeWord,
  output fsae_word_t mirrorLeWord
);

  ////////////////////////////////////////////////////////////////////////////////

  // Word served at an index within the bank; the reserved word reads as zero.
  function automatic fsae_word_t wordAt(input logic [15:0] idx, input fsae_word_t sw);
    return (idx == 16'h0000) ? sw : `FSAE_RSVD_VALUE;
  endfunction

  // True when every requested register lies inside the bank.
  function automatic logic inRange(input logic [15:0] addr, input logic [15:0] qty);
    logic [16:0] endAddr;
    logic [16:0] bankEnd;
    endAddr = {1'b0, addr} + {1'b0, qty};
    bankEnd = {1'b0, `FSAE_REG_STATUS} + {1'b0, `FSAE_REG_COUNT};
    return (addr >= `FSAE_REG_STATUS) && (endAddr <= bankEnd);
  endfunction

  fsae_state_t state_r;
  fsae_dec_t dec;
  logic [7:0] decCode;
  logic take;
  logic isRead;
  logic [15:0] startIdx;
  logic [15:0] idx_r;
  logic [15:0] left_r;
  logic diagClr_r;
  logic rspExc_r;
  logic [7:0] rspFunc_r;
  logic [7:0] rspExcCode_r;
  fsae_word_t rspWord_r;
  logic signed [MEAS_W-1:0] measOut_r;
  fsae_word_t mirrorBe_r;
  fsae_word_t mirrorLe_r;
  logic tempHigh;
  logic tempLow;
  logic measHigh;
  logic measLow;

  ////////////////////////////////////////////////////////////////////////////////

  // Range comparisons feed the live status bits.
  assign tempHigh = tempRaw > TEMP_MAX;
  assign tempLow = tempRaw < TEMP_MIN;
  assign measHigh = measRaw > MEAS_MAX;
  assign measLow = measRaw < MEAS_MIN;

  fsae_status_bank u_bank (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .parityErr(parityErr),
    .framingErr(framingErr),
    .overrunErr(overrunErr),
    .tempHigh(tempHigh),
    .tempLow(tempLow),
    .measHigh(measHigh),
    .measLow(measLow),
    .calLoadFail(calLoadFail),
    .nvLoadFail(nvLoadFail),
    .accelFail(accelFail),
    .testModeEnter(testModeEnter),
    .testModeExitCmd(testModeExitCmd),
    .wdtCause(wdtCause),
    .porCause(porCause),
    .commResetCoil(commResetCoil),
    .sensorResetCoil(sensorResetCoil),
    .diagClear(diagClr_r),
    .statusWord(statusWord)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // One request at a time: the handler only listens while idle.
  assign reqReady = (state_r == FSAE_IDLE);
  assign take = reqValid && reqReady;
  assign isRead = (reqFunc == `FSAE_FC_RD_HOLD) || (reqFunc == `FSAE_FC_RD_INPUT);
  assign startIdx = isRead ? (reqAddr - `FSAE_REG_STATUS) : 16'h0000;

  // Checks run function first, then data value, then address, as the link
  // protocol orders them; an unchecked frame never reaches the checks.
  always_comb begin
    dec = FSAE_DROP;
    decCode = `FSAE_EXC_NONE;
    if (!reqFrameOk) begin
      dec = FSAE_DROP;
    end else if (isRead) begin
      if ((reqQty == 16'h0000) || (reqQty > `FSAE_MAX_QTY)) begin
        dec = FSAE_FAULT;
        decCode = `FSAE_EXC_VALUE;
      end else if (!inRange(reqAddr, reqQty)) begin
        dec = FSAE_FAULT;
        decCode = `FSAE_EXC_ADDR;
      end else begin
        dec = FSAE_DATA;
      end
    end else if (reqFunc == `FSAE_FC_DIAG) begin
      if (reqAddr == `FSAE_SFC_RET_DIAG) begin
        dec = FSAE_DATA;
      end else if (reqAddr == `FSAE_SFC_CLR_DIAG) begin
        dec = FSAE_ECHO;
      end else begin
        dec = FSAE_FAULT;
        decCode = `FSAE_EXC_FUNC;
      end
    end else begin
      // Writes of any kind and unknown functions are refused; nothing is stored.
      dec = FSAE_FAULT;
      decCode = `FSAE_EXC_FUNC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Handler state: a word stream or one exception beat per accepted well-formed request.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_r <= FSAE_IDLE;
    end else begin
      case (state_r)
        FSAE_IDLE: begin
          if (take && (dec == FSAE_FAULT)) begin
            state_r <= FSAE_EXC;
          end else if (take && (dec != FSAE_DROP)) begin
            state_r <= FSAE_SEND;
          end
        end
        FSAE_SEND: begin
          if (rspReady && (left_r == 16'h0001)) begin
            state_r <= FSAE_IDLE;
          end
        end
        FSAE_EXC: begin
          if (rspReady) begin
            state_r <= FSAE_IDLE;
          end
        end
        default: begin
          state_r <= FSAE_IDLE;
        end
      endcase
    end
  end

  // Word index and remaining count of a read.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      idx_r <= 16'h0000;
      left_r <= 16'h0000;
    end else if (take && (dec == FSAE_DATA)) begin
      idx_r <= startIdx;
      left_r <= isRead ? reqQty : 16'h0001;
    end else if (take && (dec == FSAE_ECHO)) begin
      idx_r <= 16'h0000;
      left_r <= 16'h0001;
    end else if ((state_r == FSAE_SEND) && rspReady) begin
      idx_r <= idx_r + 16'h0001;
      left_r <= left_r - 16'h0001;
    end
  end

  // Answer fields; a status word is sampled from the flip-flops as it is loaded, the reserved word is zero and the echo word is reqQty.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rspExc_r <= 1'b0;
      rspFunc_r <= 8'h00;
      rspExcCode_r <= `FSAE_EXC_NONE;
      rspWord_r <= 16'h0000;
    end else if (take && (dec != FSAE_DROP)) begin
      rspExc_r <= (dec == FSAE_FAULT);
      rspFunc_r <= (dec == FSAE_FAULT) ? (reqFunc | `FSAE_EXC_FLAG) : reqFunc;
      rspExcCode_r <= decCode;
      rspWord_r <= (dec == FSAE_ECHO) ? reqQty : wordAt(startIdx, statusWord);
    end else if ((state_r == FSAE_SEND) && rspReady && (left_r != 16'h0001)) begin
      rspWord_r <= wordAt(idx_r + 16'h0001, statusWord);
    end
  end

  // The diagnostic clear acts one cycle after the request is taken.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      diagClr_r <= 1'b0;
    end else begin
      diagClr_r <= take && (dec == FSAE_ECHO);
    end
  end

  assign rspValid = (state_r != FSAE_IDLE);
  assign rspLast = (state_r == FSAE_EXC) || ((state_r == FSAE_SEND) && (left_r == 16'h0001));
  assign rspExc = rspExc_r;
  assign rspFunc = rspFunc_r;
  assign rspExcCode = rspExcCode_r;
  assign rspWord = rspWord_r;

  ////////////////////////////////////////////////////////////////////////////////

  // Clamped output and the two mirror copies of the status word.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      measOut_r <= '0;
      mirrorBe_r <= 16'h0000;
      mirrorLe_r <= 16'h0000;
    end else begin
      measOut_r <= measHigh ? MEAS_MAX : (measLow ? MEAS_MIN : measRaw);
      mirrorBe_r <= statusWord;
      mirrorLe_r <= {statusWord[7:0], statusWord[15:8]};
    end
  end

  assign measOut = measOut_r;
  assign mirrorBeWord = mirrorBe_r;
  assign mirrorLeWord = mirrorLe_r;

  ////////////////////////////////////////////////////////////////////////////////

  chk_bad_frame: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && !reqFrameOk |=> !rspValid) else $error("dropped frame was answered");
  chk_write_refused: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && reqFrameOk && !isRead && (reqFunc != 8'h08)
    |=> rspValid && rspExc && (rspExcCode == 8'h01) && rspLast)
    else $error("write not refused with code 01");
  chk_addr_error: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && reqFrameOk && isRead && (reqQty == 16'h0002) && (reqAddr == 16'h02BD)
    |=> rspExc && (rspExcCode == 8'h02)) else $error("overrun read not refused");
  chk_qty_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && reqFrameOk && isRead && (reqQty == 16'h0000)
    |=> rspExc && (rspExcCode == 8'h03)) else $error("zero quantity not refused");
  chk_diag_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && reqFrameOk && (reqFunc == 8'h08) && (reqAddr == 16'h0002)
    |=> !rspExc && rspLast && (rspWord == $past(statusWord)))
    else $error("diagnostic read wrong");
  chk_diag_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    take && reqFrameOk && (reqFunc == 8'h08) && (reqAddr == 16'h000A)
    |=> diagClr_r ##1 !diagClr_r) else $error("diagnostic clear not pulsed");
  chk_clamp_high: assert property (@(posedge ref_clk) disable iff (!nrst)
    measRaw > MEAS_MAX |=> (measOut == MEAS_MAX) && statusWord[4])
    else $error("high clamp failed");
  chk_clamp_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    measRaw < MEAS_MIN |=> (measOut == MEAS_MIN) && statusWord[5])
    else $error("low clamp failed");
  chk_mirror_order: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 (mirrorBeWord == $past(statusWord))
    && (mirrorLeWord == {mirrorBeWord[7:0], mirrorBeWord[15:8]}))
    else $error("mirror words wrong");

endmodule

// ==== fsae_rsp_sink.sv ====
// Answer sink: stands for the link transmitter that takes answer beats from the bank.
// Assumes it shares ref_clk and nrst with the bank and that stallEn comes from the bench.
`timescale 1ns/1ps

module fsae_rsp_sink (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic stallEn,
  output logic rspReady
);
  logic [1:0] paceCnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Slow mode takes one beat in four cycles, so every word must stand while stalled.
  // A prompt sink alone would never show a word that changes too early.
  always @(negedge ref_clk) begin
    if (!nrst) begin
      paceCnt_r <= 2'h0;
      rspReady <= 1'b0;
    end else begin
      paceCnt_r <= paceCnt_r + 2'h1;
      rspReady <= !stallEn || (paceCnt_r == 2'h3);
    end
  end
endmodule

// ==== tb_top.sv ====
// Self-checking bench of the fault/status bank: requests, events and exceptions.
// Assumes the bank, its header and the answer sink are compiled before this file.
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t %s", $time, m); end end

module tb_top
  import fsae_pkg::*;
;
  logic ref_clk = 0, nrst = 0, reqValid = 0, reqFrameOk = 1, stall = 0, wdt = 1, por = 1;
  logic [7:0] reqFunc = 0;
  logic [15:0] reqAddr = 0, reqQty = 0;
  logic [9:0] ev = 0;
  logic signed [15:0] tempRaw = 0, measRaw = 0;
  wire reqReady, rspValid, rspReady, rspExc, rspLast;
  wire [7:0] rspFunc, rspExcCode;
  wire signed [15:0] measOut;
  fsae_word_t rspWord, statusWord, mirrorBeWord, mirrorLeWord;
  int err_total = 0, checked = 0, i;
  logic [33:0] expq[$];
  logic [33:0] e;
  fsae_word_t expSt;
  logic [31:0] rs = 32'h0000_0022;
  logic [15:0] sm [7] = '{16'h0001, 16'h0002, 16'h0002, 16'h0040, 16'h0080, 16'h0100, 16'h0800};
  logic [47:0] xt [9] = '{48'h06_02BC_0005_01, 48'h10_02BC_0001_01, 48'h05_02BC_FF00_01,
    48'h03_02BC_0000_03, 48'h04_02BC_007E_03, 48'h03_02BD_0002_02, 48'h04_02BE_0001_02,
    48'h03_02BC_007D_02, 48'h08_0005_0000_01};

  fsae_fault_status i_dut (.ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid),
    .reqReady(reqReady), .reqFrameOk(reqFrameOk), .reqFunc(reqFunc), .reqAddr(reqAddr),
    .reqQty(reqQty), .rspValid(rspValid), .rspReady(rspReady), .rspExc(rspExc),
    .rspFunc(rspFunc), .rspExcCode(rspExcCode), .rspWord(rspWord), .rspLast(rspLast),
    .parityErr(ev[0]), .framingErr(ev[1]), .overrunErr(ev[2]), .tempRaw(tempRaw),
    .measRaw(measRaw), .measOut(measOut), .calLoadFail(ev[3]), .nvLoadFail(ev[4]),
    .accelFail(ev[5]), .testModeEnter(ev[6]), .testModeExitCmd(ev[7]), .wdtCause(wdt),
    .porCause(por), .commResetCoil(ev[8]), .sensorResetCoil(ev[9]),
    .statusWord(statusWord), .mirrorBeWord(mirrorBeWord), .mirrorLeWord(mirrorLeWord));
  fsae_rsp_sink i_sink (.ref_clk(ref_clk), .nrst(nrst), .stallEn(stall), .rspReady(rspReady));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock of 20 ns.
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic expect_beat(logic x, logic [7:0] f, logic [7:0] c, logic [15:0] w, logic l);
    expq.push_back({x, f, c, w, l});
  endtask

  // Offers one request when idle, then waits until every noted beat has been taken.
  task automatic req(logic [7:0] f, logic [15:0] a, logic [15:0] q, logic ok);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin @(negedge ref_clk); n++; end
    if (n >= 50) begin err_total++; wrap_up(); end
    reqFunc = f; reqAddr = a; reqQty = q; reqFrameOk = ok; reqValid = 1;
    @(negedge ref_clk);
    reqValid = 0; reqFrameOk = 1; n = 0;
    `CHK(reqReady, expq.size() == 0, "ready while answering")
    while ((rspValid !== 1'b0 || expq.size() != 0) && n < 50) begin @(negedge ref_clk); n++; end
    if (n >= 50) begin err_total++; wrap_up(); end
  endtask

  // Event pulse at one edge; the status bit shows after the next edge.
  task automatic pulse(int b);
    ev[b] = 1;
    @(negedge ref_clk);
    ev[b] = 0;
    @(negedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Answer watcher: each accepted beat is matched against the oldest note.
  // Words of an exception beat carry nothing, so they are not compared.
  always @(posedge ref_clk) begin
    if (nrst && rspValid && rspReady) begin
      if (expq.size() == 0) `CHK(1'b1, 1'b0, "answer without request")
      else begin
        e = expq.pop_front();
        `CHK(rspExc, e[33], "exception flag")
        `CHK(rspFunc, e[32:25], "answer function")
        `CHK(rspExcCode, e[24:17], "exception code")
        if (!e[33]) `CHK(rspWord, e[16:1], "answer word")
        `CHK(rspLast, e[0], "last beat")
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; boot causes are held high through reset so both bits start set.
  initial begin
    repeat (6) @(negedge ref_clk);
    nrst = 1;
    @(negedge ref_clk);
    por = 0; wdt = 0; expSt = 16'h3000;
    `CHK(statusWord, expSt, "boot causes")
    stall = 1;
    expect_beat(0, 8'h03, 8'h00, expSt, 0);
    expect_beat(0, 8'h03, 8'h00, 16'h0000, 0 + 1);
    req(8'h03, 16'h02BC, 16'h0002, 1);
    stall = 0;
    expect_beat(0, 8'h04, 8'h00, 16'h0000, 1);
    req(8'h04, 16'h02BD, 16'h0001, 1);
    expect_beat(0, 8'h08, 8'h00, expSt, 1);
    req(8'h08, 16'h0002, 16'h0000, 1);
    $display("test reads done");
    for (i = 0; i < 7; i++) begin
      if (i == 2) begin
        pulse(8);
        expSt &= ~16'h0003;
        `CHK(statusWord, expSt, "link clear")
      end
      pulse(i < 3 ? i : i);
      expSt |= sm[i];
      `CHK(statusWord, expSt, "event bit")
    end
    @(negedge ref_clk);
    `CHK(mirrorBeWord, expSt, "big-endian mirror")
    `CHK(mirrorLeWord, {expSt[7:0], expSt[15:8]}, "swapped mirror")
    $display("test events done");
    for (i = 0; i < 4; i++) begin
      tempRaw = (i == 0) ? 16'sh0056 : (i == 1) ? 16'shFFD7 : 16'sh0000;
      measRaw = (i == 2) ? 16'sh4001 : (i == 3) ? 16'shBFFF : 16'sh0000;
      repeat (2) @(negedge ref_clk);
      `CHK(statusWord, expSt | (16'h0004 << i), "range bit")
      if (i > 1) `CHK(measOut, (i == 2) ? 16'sh4000 : 16'shC000, "clamp")
      tempRaw = 0;
      measRaw = 0;
      repeat (2) @(negedge ref_clk);
      `CHK(statusWord, expSt, "range bit back")
    end
    for (i = 0; i < 8; i++) begin
      rs = xs(rs);
      measRaw = {{2{rs[14]}}, rs[13:0]};
      repeat (2) @(negedge ref_clk);
      `CHK(measOut, measRaw, "in-range pass")
    end
    $display("test ranges done");
    pulse(7);
    expSt &= ~16'h0800;
    `CHK(statusWord, expSt, "test mode exit")
    expect_beat(0, 8'h08, 8'h00, 16'h1234, 1);
    req(8'h08, 16'h000A, 16'h1234, 1);
    @(negedge ref_clk);
    expSt &= 16'h08C0;
    `CHK(statusWord, expSt, "diagnostic clear")
    pulse(9);
    expSt = 16'h0000;
    `CHK(statusWord, expSt, "sensor reset coil")
    for (i = 0; i < 9; i++) begin
      expect_beat(1, xt[i][47:40] | 8'h80, xt[i][7:0], 16'h0000, 1);
      req(xt[i][47:40], xt[i][39:24], xt[i][23:8], 1);
    end
    `CHK(statusWord, expSt, "refused writes")
    req(8'h06, 16'h02BC, 16'h0001, 0);
    expect_beat(0, 8'h03, 8'h00, 16'h0000, 1);
    req(8'h03, 16'h02BC, 16'h0001, 1);
    $display("test exceptions done");
    nrst = 0;
    wdt = 1;
    repeat (2) @(negedge ref_clk);
    nrst = 1;
    @(negedge ref_clk);
    wdt = 0;
    `CHK(statusWord, 16'h1000, "watchdog restart")
    $display("test restart done");
    wrap_up();
  end
endmodule
